// *** tfhp_top.sv ***
// Controller-facing port of the NRZI tape formatter.
// Controller and unit status pins are asynchronous; tape-side
// character events arrive on i_tape_clk; motion logic is on i_clk.
`timescale 1ns/10ps
`default_nettype none

module tfhp_top import tfhp_pkg::*; (
    // Clocks and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tape_clk,
    // Controller addressing and commands
    input wire logic i_formatter_select,
    input wire logic i_formatter_address,
    input wire logic i_unit_select_a,
    input wire logic i_unit_select_b,
    input wire logic i_cmd_clock_n,
    input wire logic i_offline_request_n,
    input wire logic i_direction_select,
    input wire logic i_tape_return_request_n,
    input wire logic i_write_mode_select,
    input wire logic i_tape_mark_write_n,
    input wire logic i_fixed_gap_clear_n,
    input wire logic i_formatter_reset_line,
    // Controller write control, modes and data
    input wire logic i_even_check_select_n,
    input wire logic i_final_char_flag_n,
    input wire logic i_high_threshold_select_n,
    input wire logic i_low_threshold_select_n,
    input wire logic i_tape_format_select,
    input wire logic [7:0] i_write_bits_n,
    // Selected unit status
    input wire logic i_write_protect_level_n,
    input wire logic i_beginning_marker_n,
    input wire logic i_ready_level_n,
    input wire logic i_remote_control_level_n,
    input wire logic i_rewinding_level_n,
    input wire logic i_tape_end_marker_n,
    input wire logic i_seven_track_level_n,
    input wire logic i_single_head_level_n,
    input wire logic i_speed_level_n,
    // Motion sequencer, same clock
    input wire logic i_op_done,
    // Tape character side, on i_tape_clk
    input wire logic i_tape_rd_stb,
    input wire logic [8:0] i_tape_rd_data,
    input wire logic i_tape_mark_seen,
    input wire logic i_tape_check_seen,
    input wire logic i_tape_error_seen,
    input wire logic i_tape_wr_take,
    // Status to controller
    output logic o_tape_mark_pulse_n,
    output logic o_hard_error_n,
    output logic o_corrected_error_pulse_n,
    output logic o_write_protect_level_n,
    output logic o_beginning_marker_n,
    output logic o_ready_level_n,
    output logic o_remote_control_level_n,
    output logic o_rewinding_level_n,
    output logic o_tape_end_marker_n,
    output logic o_seven_track_level_n,
    output logic o_single_head_level_n,
    output logic o_speed_level_n,
    output logic o_phase_mode_flag,
    output logic o_formatter_active_n,
    output logic o_transfer_active_n,
    output logic o_check_char_detect_pulse_n,
    // Read and write data to controller
    output logic o_read_check_bit_n,
    output logic [7:0] o_read_bits_n,
    output logic o_read_char_pulse_n,
    output logic o_write_char_pulse_n,
    // Unit and motion commands
    output logic [3:0] o_unit_select_n,
    output logic o_unit_offline,
    output logic o_unit_rewind,
    output logic o_op_start,
    output logic o_op_reverse,
    output logic o_op_write,
    output logic o_op_mark,
    output logic o_op_erase,
    output logic o_high_threshold,
    output logic o_low_threshold,
    output logic o_low_density,
    output logic o_nrzi_selected,
    // Tape character side, on i_tape_clk
    output logic [8:0] o_tape_wr_data,
    output logic o_tape_wr_valid,
    output logic o_tape_wr_last
);
    localparam int PW = PULSE_CYC;

    function automatic logic [SYNC_W-1:0] settle(
        input logic [SYNC_W-1:0] a,
        input logic [SYNC_W-1:0] b,
        input logic [SYNC_W-1:0] old
    );
        settle = (~(a ^ b) & b) | ((a ^ b) & old);
    endfunction

    function automatic logic [PULSE_W-1:0] pulse_step(
        input logic [PULSE_W-1:0] cnt,
        input logic ev
    );
        if (ev)
            pulse_step = PULSE_LOAD;
        else if (cnt != PULSE_ZERO)
            pulse_step = cnt - PULSE_ONE;
        else
            pulse_step = PULSE_ZERO;
    endfunction

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] s1, s2, s3, flt;
    logic f_fsel, f_ua, f_ub, f_clk_n, f_off_n, f_dir, f_ret_n, f_wms;
    logic f_mark_n, f_gap_n, f_rst, f_even_n, f_final_n, f_hi_n, f_lo_n, f_fmt;
    logic [7:0] f_wd_n;
    logic f_addr, f_protect_n, f_begin_n, f_ready_n, f_remote_n;
    logic f_rewinding_n, f_end_n, f_seven_n, f_single_n, f_speed_n;
    logic clk_q, off_q, ret_q;
    logic cmd_rise, addressed, accept;
    logic wr_cmd, mark_cmd, erase_cmd;
    tfhp_state_t state;
    logic [EVT_W-1:0] tvec, e1, e2, e3, ev;
    logic ev_rd, ev_mark, ev_chk, ev_err, ev_req;
    logic [8:0] wr_word;
    logic wr_last, wr_toggle, wr_done, cap_first, cap, seven, even_sel;
    logic [7:0] wd;
    logic wpar;
    logic [PULSE_W-1:0] cnt_rs, cnt_ws, cnt_mk, cnt_cc;
    logic rd_go;
    logic tt_rd, tt_mark, tt_chk, tt_err, tt_req;
    logic [8:0] rd_hold;
    logic w1, w2, w3;

    assign sync_in = {i_formatter_select, i_unit_select_a, i_unit_select_b,
        i_cmd_clock_n, i_offline_request_n, i_direction_select,
        i_tape_return_request_n, i_write_mode_select, i_tape_mark_write_n,
        i_fixed_gap_clear_n, i_formatter_reset_line, i_even_check_select_n,
        i_final_char_flag_n, i_high_threshold_select_n,
        i_low_threshold_select_n, i_tape_format_select, i_write_bits_n,
        i_formatter_address, i_write_protect_level_n, i_beginning_marker_n,
        i_ready_level_n, i_remote_control_level_n, i_rewinding_level_n,
        i_tape_end_marker_n, i_seven_track_level_n, i_single_head_level_n,
        i_speed_level_n};

    assign {f_fsel, f_ua, f_ub, f_clk_n, f_off_n, f_dir, f_ret_n, f_wms,
        f_mark_n, f_gap_n, f_rst, f_even_n, f_final_n, f_hi_n, f_lo_n, f_fmt,
        f_wd_n, f_addr, f_protect_n, f_begin_n, f_ready_n, f_remote_n,
        f_rewinding_n, f_end_n, f_seven_n, f_single_n, f_speed_n} = flt;

    // A change counts only once stages two and three agree
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
            flt <= '1;
        end
        else
        begin
            s1 <= sync_in;
            s2 <= s1;
            s3 <= s2;
            flt <= settle(s2, s3, flt);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            clk_q <= 1'b1;
            off_q <= 1'b1;
            ret_q <= 1'b1;
        end
        else
        begin
            clk_q <= f_clk_n;
            off_q <= f_off_n;
            ret_q <= f_ret_n;
        end
    end

    // Filtering delays all command lines alike, so the hold
    // margin around the clock keeps them valid at its rising edge
    assign cmd_rise = f_clk_n & ~clk_q;
    assign addressed = (~f_fsel) == f_addr;
    assign accept = cmd_rise & addressed & ~f_rst & (state == ST_IDLE);
    assign wr_cmd = ~f_wms;
    assign mark_cmd = wr_cmd & ~f_mark_n;
    assign erase_cmd = mark_cmd & ~f_gap_n;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            state <= ST_IDLE;
        else if (f_rst)
            state <= ST_IDLE;
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (accept && erase_cmd)
                        state <= ST_ERASE;
                    else if (accept && mark_cmd)
                        state <= ST_MARK;
                    else if (accept)
                        state <= ST_XFER;
                end
                ST_XFER, ST_MARK, ST_ERASE:
                begin
                    if (i_op_done)
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Command and mode latch
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_op_start <= 1'b0;
            o_op_reverse <= 1'b0;
            o_op_write <= 1'b0;
            o_op_mark <= 1'b0;
            o_op_erase <= 1'b0;
            o_high_threshold <= 1'b0;
            o_low_threshold <= 1'b0;
            o_low_density <= 1'b0;
            o_nrzi_selected <= 1'b0;
            o_phase_mode_flag <= 1'b0;
        end
        else
        begin
            o_op_start <= accept;
            if (accept)
            begin
                o_op_reverse <= ~f_dir;
                o_op_write <= wr_cmd;
                o_op_mark <= mark_cmd & ~erase_cmd;
                o_op_erase <= erase_cmd;
                o_high_threshold <= ~f_single_n & ~f_hi_n;
                o_low_threshold <= ~f_single_n & ~f_lo_n;
                o_low_density <= ~f_fmt & ~f_seven_n;
                o_nrzi_selected <= ~f_fmt;
                o_phase_mode_flag <= f_fmt;
            end
        end
    end

    // Offline and rewind bypass the command clock
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_unit_offline <= 1'b0;
            o_unit_rewind <= 1'b0;
            o_unit_select_n <= UNIT_NONE_N;
        end
        else
        begin
            o_unit_offline <= ~f_off_n & off_q & addressed;
            o_unit_rewind <= ~f_ret_n & ret_q & addressed;
            // Follows the lines whenever addressed, so a new unit may be
            // picked while another one rewinds
            if (addressed)
                o_unit_select_n <= ~(UNIT_ONE << {~f_ua, ~f_ub});
            else
                o_unit_select_n <= UNIT_NONE_N;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_write_protect_level_n <= 1'b1;
            o_beginning_marker_n <= 1'b1;
            o_ready_level_n <= 1'b1;
            o_remote_control_level_n <= 1'b1;
            o_rewinding_level_n <= 1'b1;
            o_tape_end_marker_n <= 1'b1;
            o_seven_track_level_n <= 1'b1;
            o_single_head_level_n <= 1'b1;
            o_speed_level_n <= 1'b1;
            o_formatter_active_n <= 1'b1;
            o_transfer_active_n <= 1'b1;
            o_corrected_error_pulse_n <= 1'b1;
        end
        else
        begin
            o_write_protect_level_n <= f_protect_n | ~addressed;
            o_beginning_marker_n <= f_begin_n | ~addressed;
            o_ready_level_n <= f_ready_n | ~addressed;
            o_remote_control_level_n <= f_remote_n | ~addressed;
            o_rewinding_level_n <= f_rewinding_n | ~addressed;
            o_tape_end_marker_n <= f_end_n | ~addressed;
            o_seven_track_level_n <= f_seven_n | ~addressed;
            o_single_head_level_n <= f_single_n | ~addressed;
            o_speed_level_n <= f_speed_n | ~addressed;
            o_formatter_active_n <= (state == ST_IDLE);
            o_transfer_active_n <= (state != ST_XFER);
            o_corrected_error_pulse_n <= 1'b1;
        end
    end

    // Tape-side events enter as toggles
    assign tvec = {tt_rd, tt_mark, tt_chk, tt_err, tt_req};
    assign ev = e2 ^ e3;
    assign {ev_rd, ev_mark, ev_chk, ev_err, ev_req} = ev;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            e1 <= '0;
            e2 <= '0;
            e3 <= '0;
        end
        else
        begin
            e1 <= tvec;
            e2 <= e1;
            e3 <= e2;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_hard_error_n <= 1'b1;
        else if (ev_err)
            o_hard_error_n <= 1'b0;
        else if (accept || f_rst)
            o_hard_error_n <= 1'b1;
    end

    // Write path: first character is taken right after the command,
    // each later one when the tape side has consumed the previous
    assign seven = ~f_seven_n;
    assign even_sel = seven & ~f_even_n;
    assign wd = ~f_wd_n;
    assign wpar = even_sel ? ^wd : ~^wd;
    assign cap = ~f_rst & (cap_first | (ev_req & (state == ST_XFER) & o_op_write & ~wr_done));

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cap_first <= 1'b0;
            wr_word <= '0;
            wr_last <= 1'b0;
            wr_toggle <= 1'b0;
            wr_done <= 1'b0;
        end
        else
        begin
            cap_first <= accept & wr_cmd & ~mark_cmd;
            if (cap)
            begin
                wr_word <= {wpar, wd};
                wr_last <= ~f_final_n;
                wr_toggle <= ~wr_toggle;
            end
            if (cap && !f_final_n)
                wr_done <= 1'b1;
            else if (accept || f_rst)
                wr_done <= 1'b0;
        end
    end

    assign rd_go = ev_rd & (state == ST_XFER) & ~o_op_write & ~f_rst;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_read_check_bit_n <= 1'b1;
            o_read_bits_n <= 8'hff;
        end
        else if (rd_go)
        begin
            o_read_check_bit_n <= ~rd_hold[8];
            o_read_bits_n <= ~rd_hold[7:0];
        end
    end

    // Pulse widths come from the crystal clock, not one-shots
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cnt_rs <= PULSE_ZERO;
            cnt_ws <= PULSE_ZERO;
            cnt_mk <= PULSE_ZERO;
            cnt_cc <= PULSE_ZERO;
            o_read_char_pulse_n <= 1'b1;
            o_write_char_pulse_n <= 1'b1;
            o_tape_mark_pulse_n <= 1'b1;
            o_check_char_detect_pulse_n <= 1'b1;
        end
        else
        begin
            cnt_rs <= pulse_step(cnt_rs, rd_go);
            cnt_ws <= pulse_step(cnt_ws, cap);
            cnt_mk <= pulse_step(cnt_mk, ev_mark);
            cnt_cc <= pulse_step(cnt_cc, ev_chk);
            o_read_char_pulse_n <= ~(rd_go | (cnt_rs != PULSE_ZERO));
            o_write_char_pulse_n <= ~(cap | (cnt_ws != PULSE_ZERO));
            o_tape_mark_pulse_n <= ~(ev_mark | (cnt_mk != PULSE_ZERO));
            o_check_char_detect_pulse_n <= ~(ev_chk | (cnt_cc != PULSE_ZERO));
        end
    end

    // Tape clock domain; held words stay put until the next toggle
    always_ff @(posedge i_tape_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tt_rd <= 1'b0;
            tt_mark <= 1'b0;
            tt_chk <= 1'b0;
            tt_err <= 1'b0;
            rd_hold <= '0;
        end
        else
        begin
            if (i_tape_rd_stb)
            begin
                rd_hold <= i_tape_rd_data;
                tt_rd <= ~tt_rd;
            end
            if (i_tape_mark_seen)
                tt_mark <= ~tt_mark;
            if (i_tape_check_seen)
                tt_chk <= ~tt_chk;
            if (i_tape_error_seen)
                tt_err <= ~tt_err;
        end
    end

    always_ff @(posedge i_tape_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            w1 <= 1'b0;
            w2 <= 1'b0;
            w3 <= 1'b0;
            tt_req <= 1'b0;
            o_tape_wr_data <= '0;
            o_tape_wr_valid <= 1'b0;
            o_tape_wr_last <= 1'b0;
        end
        else
        begin
            w1 <= wr_toggle;
            w2 <= w1;
            w3 <= w2;
            if (w2 ^ w3)
            begin
                o_tape_wr_data <= wr_word;
                o_tape_wr_last <= wr_last;
                o_tape_wr_valid <= 1'b1;
            end
            else if (i_tape_wr_take && o_tape_wr_valid)
            begin
                o_tape_wr_valid <= 1'b0;
                tt_req <= ~tt_req;
            end
        end
    end

    unit_decode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (addressed && !f_ua && f_ub) |=> (o_unit_select_n == 4'hb))
        else $error("unit select decode wrong");

    cmd_latch_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        accept |=> (state != ST_IDLE) && o_op_start ##1 !o_op_start)
        else $error("command not latched on clock edge");

    offline_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (addressed && $fell(f_off_n)) |=> o_unit_offline ##1 !o_unit_offline)
        else $error("offline request not passed on");

    rewind_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (addressed && $fell(f_ret_n)) |=> o_unit_rewind)
        else $error("rewind request not passed on");

    erase_select_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (accept && erase_cmd) |=> (state == ST_ERASE) && !o_op_mark ##1 o_op_erase)
        else $error("erase not selected");

    mark_select_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (accept && mark_cmd && !erase_cmd) |=> (state == ST_MARK))
        else $error("file mark not selected");

    fmt_reset_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        f_rst |=> (state == ST_IDLE) ##1 o_formatter_active_n)
        else $error("reset line left an operation running");

    read_width_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $fell(o_read_char_pulse_n) |-> ##[PW:PW] $rose(o_read_char_pulse_n))
        else $error("read pulse width wrong");

    mark_width_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $fell(o_tape_mark_pulse_n) |-> !o_tape_mark_pulse_n [*8])
        else $error("mark pulse too short");

    last_char_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_done && !accept) |=> !cap || f_rst || cap_first)
        else $error("write data requested after final character");

    corrected_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ##1 o_corrected_error_pulse_n)
        else $error("corrected error asserted");

    busy_track_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state == ST_XFER) |=> !o_formatter_active_n && !o_transfer_active_n)
        else $error("busy outputs do not follow operation");

    tape_load_a: assert property (@(posedge i_tape_clk) disable iff (i_sys_rst)
        (w2 ^ w3) |=> o_tape_wr_valid && (o_tape_wr_data == $past(wr_word)))
        else $error("write character not handed to tape side");

endmodule

`default_nettype wire

// *** tfhp_pkg.sv ***
// Shared constants for the tape formatter host port.
// Assumes a 100 MHz internal clock; controller lines are asynchronous.
// Functional notes
// - Two select lines pick one of four units
// - Commands latch on command clock trailing edge
// - Offline request pulse takes selected unit offline
// - Return request pulse starts rewind on unit
// - Low direction reverse; low mode line write
// - Mark line plus write mode writes mark
// - All three low erases fixed gap only
// - Reset line high clears every operation
// - Seven-track: even check when select low
// - Final flag with last character ends requests
// - Modes latch on clock; thresholds single-gap only
// - Format low selects us; seven-track low density
// - Eight low-true write bits, msb first
// - Detected mark gives one microsecond low pulse
// - Hard error low level; corrected never asserted
// - Selected unit status levels, phase flag high
// - Busy low during operation, transfer busy too
// - Check characters detected give low pulse
// - Read character on nine low-true lines
// - One microsecond read pulse per character
// - One write pulse per character, data follows
// - Respond to our configured formatter address
`default_nettype none

package tfhp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYC = (PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : PULSE_NS / CLK_PERIOD_NS;
    localparam int PULSE_W = 8;
    localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYC - 1);
    localparam logic [PULSE_W-1:0] PULSE_ZERO = 8'h00;
    localparam logic [PULSE_W-1:0] PULSE_ONE = 8'h01;
    localparam int SYNC_W = 34;
    localparam int EVT_W = 5;
    localparam logic [3:0] UNIT_ONE = 4'h1;
    localparam logic [3:0] UNIT_NONE_N = 4'hf;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_XFER = 4'h2,
        ST_MARK = 4'h4,
        ST_ERASE = 4'h8
    } tfhp_state_t;
endpackage

`default_nettype wire

// *** tfhp_ctrl_model.sv ***
// Controller write-data model for the tape formatter host port.
// Assumes the formatter paces each character with a low strobe.
`timescale 1ns/10ps
`default_nettype none
module tfhp_ctrl_model (
    // Control
    input wire logic i_rst,
    input wire logic i_write_char_pulse_n,
    // Write data to formatter
    output logic [7:0] o_write_bits_n,
    output logic o_final_char_flag_n
);
    logic [1:0] idx;
    // First character stands before the first strobe
    always @(posedge i_write_char_pulse_n or posedge i_rst)
    begin
        if (i_rst)
            idx <= 2'h0;
        else
            idx <= idx + 2'h1;
    end
    assign o_write_bits_n = ~(8'h30 + {6'h00, idx});
    assign o_final_char_flag_n = (idx != 2'h2);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the tape formatter host port.
// Drives controller and tape sides; write data comes from the model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
    logic i_clk = 0, i_sys_rst = 1, i_tape_clk = 0, i_formatter_select = 0, i_formatter_address = 1;
    logic i_unit_select_a = 1, i_unit_select_b = 1, i_cmd_clock_n = 1, i_offline_request_n = 1;
    logic i_direction_select = 1, i_tape_return_request_n = 1, i_write_mode_select = 1;
    logic i_tape_mark_write_n = 1, i_fixed_gap_clear_n = 1, i_formatter_reset_line = 0;
    logic i_even_check_select_n = 1, i_high_threshold_select_n = 1, i_low_threshold_select_n = 1;
    logic i_tape_format_select = 0, i_final_char_flag_n, model_rst = 1, i_op_done = 0;
    logic i_tape_rd_stb = 0, i_tape_mark_seen = 0, i_tape_check_seen = 0, i_tape_error_seen = 0;
    logic i_tape_wr_take = 0, o_tape_mark_pulse_n, o_hard_error_n, o_corrected_error_pulse_n;
    logic o_phase_mode_flag, o_formatter_active_n, o_transfer_active_n, o_check_char_detect_pulse_n;
    logic o_read_check_bit_n, o_read_char_pulse_n, o_write_char_pulse_n, o_unit_offline, o_unit_rewind;
    logic o_op_start, o_op_reverse, o_op_write, o_op_mark, o_op_erase, o_high_threshold;
    logic o_low_threshold, o_low_density, o_nrzi_selected, o_tape_wr_valid, o_tape_wr_last;
    logic [7:0] i_write_bits_n, o_read_bits_n;
    logic [3:0] o_unit_select_n;
    logic [8:0] st = 9'h1ff, sto, i_tape_rd_data = 9'h000, o_tape_wr_data;
    int mismatches = 0, n_tests = 0, strobes = 0, offs = 0, rews = 0, starts = 0, w;
    tfhp_top dut_u (.*, .i_write_protect_level_n(st[8]), .i_beginning_marker_n(st[7]),
        .i_ready_level_n(st[6]), .i_remote_control_level_n(st[5]), .i_rewinding_level_n(st[4]),
        .i_tape_end_marker_n(st[3]), .i_seven_track_level_n(st[2]), .i_single_head_level_n(st[1]),
        .i_speed_level_n(st[0]), .o_write_protect_level_n(sto[8]), .o_beginning_marker_n(sto[7]),
        .o_ready_level_n(sto[6]), .o_remote_control_level_n(sto[5]), .o_rewinding_level_n(sto[4]),
        .o_tape_end_marker_n(sto[3]), .o_seven_track_level_n(sto[2]), .o_single_head_level_n(sto[1]),
        .o_speed_level_n(sto[0]));
    tfhp_ctrl_model model_u (.i_rst(model_rst), .i_write_char_pulse_n(o_write_char_pulse_n),
        .o_write_bits_n(i_write_bits_n), .o_final_char_flag_n(i_final_char_flag_n));
    initial forever #5 i_clk = ~i_clk;
    initial #33 forever #80 i_tape_clk = ~i_tape_clk;
    always @(negedge o_write_char_pulse_n) strobes++;
    always @(posedge i_clk) offs += int'(o_unit_offline);
    always @(posedge i_clk) rews += int'(o_unit_rewind);
    always @(posedge i_clk) starts += int'(o_op_start);
    task step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_tape_clk);
        #1;
    endtask
    // Lines set 500 ns before the clock pulse and held 550 ns after it
    task cmd(input logic dir, wr, mk, gap);
        {i_direction_select, i_write_mode_select, i_tape_mark_write_n, i_fixed_gap_clear_n} = {dir, wr, mk, gap};
        step(50);
        i_cmd_clock_n = 0;
        step(10);
        i_cmd_clock_n = 1;
        step(55);
    endtask
    task done;
        i_op_done = 1;
        step(1);
        i_op_done = 0;
        step(8);
    endtask
    task t_units;
        st = 9'h0a5;
        for (int u = 0; u < 4; u++)
        begin
            {i_unit_select_a, i_unit_select_b} = ~2'(u);
            step(8);
            `CHK("unit", 4'(~(4'h1 << u)), o_unit_select_n)
        end
        `CHK("status", 9'h0a5, sto)
        {i_offline_request_n, i_tape_return_request_n} = 2'b00;
        step(10);
        {i_offline_request_n, i_tape_return_request_n} = 2'b11;
        step(10);
        `CHK("offline", 2'b11, {offs == 1, rews == 1})
        i_formatter_select = 1;
        step(8);
        `CHK("unaddr", 4'hf, o_unit_select_n)
        i_formatter_select = 0;
        step(8);
        $display("units done");
    endtask
    task t_read;
        i_high_threshold_select_n = 0;
        cmd(1, 1, 1, 1);
        `CHK("read", 2'b00, {o_op_reverse, o_op_write})
        `CHK("busy", 3'b001, {o_transfer_active_n, o_formatter_active_n, o_nrzi_selected})
        `CHK("modes", 3'b100, {o_high_threshold, o_low_threshold, o_phase_mode_flag})
        tick(1);
        i_tape_rd_data = 9'h13c;
        i_tape_rd_stb = 1;
        tick(1);
        i_tape_rd_stb = 0;
        for (w = 0; o_read_char_pulse_n !== 0 && w < 50; w++) step(1);
        `CHK("rdata", ~9'h13c, {o_read_check_bit_n, o_read_bits_n})
        for (w = 0; o_read_char_pulse_n === 0 && w < 200; w++) step(1);
        `CHK("rpulse", 100, w)
        done();
        `CHK("idle", 1'b1, o_formatter_active_n)
        $display("read done");
    endtask
    task t_write;
        model_rst = 0;
        i_even_check_select_n = 0;
        cmd(1, 0, 1, 1);
        `CHK("wmode", 1'b1, o_op_write)
        for (int k = 0; k < 3; k++)
        begin
            for (w = 0; o_tape_wr_valid !== 1 && w < 400; w++) step(1);
            `CHK("wdata", {~^(8'h30 + 8'(k)), 8'h30 + 8'(k)}, o_tape_wr_data)
            `CHK("wlast", k == 2, o_tape_wr_last)
            for (w = 0; o_write_char_pulse_n !== 1 && w < 400; w++) step(1);
            tick(2);
            i_tape_wr_take = 1;
            tick(1);
            i_tape_wr_take = 0;
        end
        step(300);
        `CHK("strobes", 3, strobes)
        done();
        $display("write done");
    endtask
    task t_marks;
        {st[2], i_low_threshold_select_n} = 2'b00;
        cmd(1, 0, 0, 1);
        `CHK("mark", 4'b1011, {o_op_mark, o_op_erase, o_low_density, o_low_threshold})
        done();
        cmd(0, 0, 0, 0);
        `CHK("erase", 2'b11, {o_op_erase, o_op_reverse})
        i_formatter_reset_line = 1;
        step(10);
        `CHK("fen", 1'b1, o_formatter_active_n)
        i_formatter_reset_line = 0;
        tick(1);
        {i_tape_mark_seen, i_tape_check_seen, i_tape_error_seen} = 3'b111;
        tick(1);
        {i_tape_mark_seen, i_tape_check_seen, i_tape_error_seen} = 3'b000;
        for (w = 0; o_tape_mark_pulse_n !== 0 && w < 50; w++) step(1);
        `CHK("fmk", 2'b00, {o_tape_mark_pulse_n, o_check_char_detect_pulse_n})
        `CHK("err", 2'b01, {o_hard_error_n, o_corrected_error_pulse_n})
        `CHK("starts", 4, starts)
        $display("marks done");
    endtask
    task give_verdict;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #300000;
        mismatches++;
        give_verdict();
    end
    initial
    begin
        step(12);
        i_sys_rst = 0;
        step(10);
        t_units();
        t_read();
        t_write();
        t_marks();
        give_verdict();
    end
endmodule
`default_nettype wire
